// ---- src/ram_overlay_flash_emulation.sv ----
// Summary of operation
// [RQ1] With overlay on, RAM FFF000-FFF1FF answers in place of the selected flash window.
// [RQ2] Only control bits 3..0 steer the remap: one enable and a 3-bit select.
// [RQ3] Overlaid RAM stays reachable through its own address range as well.
// [RQ4] Enable 0 means no overlay; select n maps window 01F000 plus n times 200.
// [RQ5] Reset and hardware standby clear the error flag and the four control bits.
// [RQ6] Software standby leaves the error flag and control bits unchanged.
// [RQ7] Control bits are writable only in operating modes 5, 6 and 7.
// [RQ8] In other modes control bits read as zero and writes are ignored.
// [RQ9] Software clears the enable before really programming or erasing flash.
// [RQ10] Error during program or erase sets a sticky flag that blocks further program/erase.
// [RQ11] Reads and writes in the overlaid window go to RAM, never to flash.
//
// Decided for this implementation: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ram_overlay_defs.svh"
module ram_overlay_flash_emulation
	import ram_overlay_pkg::*;
#(
	parameter int RAM_DEPTH = `RO_RAM_BYTES
) (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic resetn,
	// Chip state.
	input wire logic [2:0] opMode,
	input wire logic hwStandby,
	input wire logic swStandby,
	input wire logic flashBusy,
	input wire logic flashErrorCond,
	// Avalon-MM register slave.
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Core memory access.
	input wire addr_t cpuAddr,
	input wire logic cpuRead,
	input wire logic cpuWrite,
	input wire logic [7:0] cpuWdata,
	output logic [7:0] cpuRdata,
	output logic cpuAck,
	// Downstream flash access.
	output addr_t flashAddr,
	output logic flashRead,
	output logic flashWrite,
	output logic [7:0] flashWdata,
	input wire logic [7:0] flashRdata,
	input wire logic flashAck,
	// Flash status.
	output logic flashErrorFlag,
	output logic progEraseBlocked
);
	function automatic logic flashModeOk(input logic [2:0] m);
		flashModeOk = (m == `RO_MODE_A) || (m == `RO_MODE_B) || (m == `RO_MODE_C);
	endfunction

	logic [3:0] ctrl_reg, ctrl_next;
	logic err_reg, err_next;
	logic wait_reg, wait_next;
	logic [31:0] rdata_reg, rdata_next;
	logic modeOk, busDone, ctrlWrite;

	assign modeOk = flashModeOk(opMode);
	assign busDone = (avs_read || avs_write) && !wait_reg;
	assign ctrlWrite = busDone && avs_write && avs_address == `RO_CTRL_OFFSET && avs_byteenable[0];

	always_comb begin
		ctrl_next = ctrl_reg;
		err_next = err_reg;
		wait_next = 1'b1;
		rdata_next = rdata_reg;
		if ((avs_read || avs_write) && wait_reg) begin
			wait_next = 1'b0;
			rdata_next = 32'h00000000;
			if (avs_read && avs_address == `RO_CTRL_OFFSET) begin
				rdata_next[`RO_ERR_BIT] = err_reg;
				rdata_next[`RO_RSVD_HI:`RO_RSVD_LO] = `RO_RSVD_VAL;
				rdata_next[`RO_EN_BIT:`RO_SEL_LO] = modeOk ? ctrl_reg : 4'h0; // see [RQ8]
			end
		end
		if (ctrlWrite && modeOk) begin
			ctrl_next = avs_writedata[`RO_EN_BIT:`RO_SEL_LO]; // see [RQ7]
		end
		if (!modeOk) begin
			ctrl_next = `RO_CTRL_RESET; // see [RQ8]
		end
		// The flag is read-only; only a fault during program or erase sets it.
		if (flashErrorCond && flashBusy) begin
			err_next = 1'b1; // see [RQ10]
		end
		// Software standby has no term here, so state simply holds through it.
		if (hwStandby) begin
			ctrl_next = `RO_CTRL_RESET; // see [RQ5]
			err_next = 1'b0; // see [RQ5]
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			ctrl_reg <= `RO_CTRL_RESET;
			err_reg <= 1'b0;
			wait_reg <= 1'b1;
			rdata_reg <= 32'h00000000;
		end else begin
			ctrl_reg <= ctrl_next;
			err_reg <= err_next;
			wait_reg <= wait_next;
			rdata_reg <= rdata_next;
		end
	end

	assign avs_waitrequest = wait_reg;
	assign avs_readdata = rdata_reg;
	assign flashErrorFlag = err_reg;
	assign progEraseBlocked = err_reg; // see [RQ10]

	logic ramHit, overlayHit;
	logic [8:0] ramIndex;

	overlay_decoder u_dec (
		.addr(cpuAddr),
		.overlayEn(ctrl_reg[`RO_EN_BIT]), // see [RQ2]
		.windowSel(ctrl_reg[`RO_SEL_HI:`RO_SEL_LO]),
		.ramHit(ramHit),
		.overlayHit(overlayHit),
		.ramIndex(ramIndex)
	);

	// RAM array held in flip-flops; no reset, contents are software data.
	logic [7:0] ram_reg [RAM_DEPTH];
	logic ramWe;

	acc_state_e state_reg, state_next;
	logic [7:0] crd_reg, crd_next;
	logic ack_reg, ack_next;
	addr_t faddr_reg, faddr_next;
	logic frd_reg, frd_next, fwr_reg, fwr_next;
	logic [7:0] fwd_reg, fwd_next;

	always_comb begin
		state_next = state_reg;
		crd_next = crd_reg;
		ack_next = 1'b0;
		faddr_next = faddr_reg;
		frd_next = frd_reg;
		fwr_next = fwr_reg;
		fwd_next = fwd_reg;
		ramWe = 1'b0;
		case (state_reg)
			ACC_IDLE: begin
				if (cpuRead || cpuWrite) begin
					if (ramHit) begin
						// Overlaid window is served by RAM and flash sees nothing.
						ramWe = cpuWrite; // see [RQ11]
						crd_next = cpuRead ? ram_reg[ramIndex] : crd_reg; // see [RQ1]
						ack_next = 1'b1;
						state_next = ACC_DONE;
					end else begin
						faddr_next = cpuAddr;
						frd_next = cpuRead;
						fwr_next = cpuWrite;
						fwd_next = cpuWdata;
						state_next = ACC_FLASH;
					end
				end
			end
			ACC_FLASH: begin
				if (flashAck) begin
					frd_next = 1'b0;
					fwr_next = 1'b0;
					crd_next = frd_reg ? flashRdata : crd_reg;
					ack_next = 1'b1;
					state_next = ACC_DONE;
				end
			end
			ACC_DONE: begin
				// One idle cycle lets the core drop its request after the ack.
				state_next = ACC_IDLE;
			end
			default: begin
				state_next = ACC_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			state_reg <= ACC_IDLE;
			crd_reg <= 8'h00;
			ack_reg <= 1'b0;
			faddr_reg <= 24'h000000;
			frd_reg <= 1'b0;
			fwr_reg <= 1'b0;
			fwd_reg <= 8'h00;
		end else begin
			state_reg <= state_next;
			crd_reg <= crd_next;
			ack_reg <= ack_next;
			faddr_reg <= faddr_next;
			frd_reg <= frd_next;
			fwr_reg <= fwr_next;
			fwd_reg <= fwd_next;
		end
	end

	always_ff @(posedge core_clk) begin
		if (ramWe) begin
			ram_reg[ramIndex] <= cpuWdata;
		end
	end

	assign cpuRdata = crd_reg;
	assign cpuAck = ack_reg;
	assign flashAddr = faddr_reg;
	assign flashRead = frd_reg;
	assign flashWrite = fwr_reg;
	assign flashWdata = fwd_reg;

	overlay_route_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RQ1]
		state_reg == ACC_IDLE && cpuRead && overlayHit |=> cpuAck && !flashRead)
		else $error("overlay read not served by RAM");

	ctrl_readback_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RQ2]
		avs_read && wait_reg && avs_address == `RO_CTRL_OFFSET && modeOk && !ctrlWrite
		|=> avs_readdata[`RO_EN_BIT:`RO_SEL_LO] == $past(ctrl_reg)
		&& avs_readdata[`RO_RSVD_HI:`RO_RSVD_LO] == `RO_RSVD_VAL)
		else $error("control readback wrong");

	ram_alias_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RQ3]
		state_reg == ACC_IDLE && (cpuRead || cpuWrite)
		&& (cpuAddr >> `RO_BLOCK_LSB) == (`RO_RAM_BASE >> `RO_BLOCK_LSB)
		|=> cpuAck ##1 state_reg == ACC_IDLE)
		else $error("original RAM range not served");

	no_overlay_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RQ4]
		!ctrl_reg[`RO_EN_BIT] && cpuAddr <= `RO_FLASH_TOP |-> !ramHit)
		else $error("overlay active while disabled");

	standby_clear_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RQ5]
		hwStandby |=> ctrl_reg == `RO_CTRL_RESET && !flashErrorFlag)
		else $error("hardware standby did not clear");

	soft_standby_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RQ6]
		swStandby && !hwStandby && !ctrlWrite && modeOk && !flashErrorCond
		|=> $stable(ctrl_reg) && $stable(flashErrorFlag))
		else $error("software standby changed state");

	mode_lock_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RQ8]
		!modeOk |=> ctrl_reg == `RO_CTRL_RESET)
		else $error("control bits alive outside flash modes");

	mode_write_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RQ7]
		ctrlWrite && modeOk && !hwStandby
		|=> ctrl_reg == $past(avs_writedata[`RO_EN_BIT:`RO_SEL_LO]))
		else $error("control write lost");

	error_sticky_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RQ10]
		((flashErrorCond && flashBusy) || flashErrorFlag) && !hwStandby
		|=> flashErrorFlag && progEraseBlocked)
		else $error("error flag not held");

	window_write_a: assert property (@(posedge core_clk) disable iff (!resetn) // see [RQ11]
		state_reg == ACC_IDLE && cpuWrite && overlayHit |=> !flashWrite [*2])
		else $error("overlay write leaked to flash");
endmodule
`default_nettype wire

// ---- src/ram_overlay_defs.svh ----
`ifndef RAM_OVERLAY_DEFS_SVH
`define RAM_OVERLAY_DEFS_SVH

// Address map of the core side.
`define RO_ADDR_W 24
`define RO_RAM_BASE 24'hfff000
`define RO_WIN_BASE 24'h01f000
`define RO_FLASH_TOP 24'h01ffff
`define RO_BLOCK_LSB 9
`define RO_RAM_BYTES 512

// Control register layout.
`define RO_CTRL_OFFSET 4'h0
`define RO_ERR_BIT 7
`define RO_RSVD_HI 6
`define RO_RSVD_LO 4
`define RO_RSVD_VAL 3'h7
`define RO_EN_BIT 3
`define RO_SEL_HI 2
`define RO_SEL_LO 0
`define RO_CTRL_RESET 4'h0

// Operating modes with on-chip flash enabled.
`define RO_MODE_A 3'h5
`define RO_MODE_B 3'h6
`define RO_MODE_C 3'h7

`endif

// ---- src/ram_overlay_pkg.sv ----
package ram_overlay_pkg;
	typedef logic [23:0] addr_t;
	typedef enum logic [1:0] {
		ACC_IDLE = 2'b00,
		ACC_FLASH = 2'b01,
		ACC_DONE = 2'b10
	} acc_state_e;
endpackage

// ---- src/overlay_decoder.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ram_overlay_defs.svh"
module overlay_decoder
	import ram_overlay_pkg::*;
(
	// Access address.
	input wire addr_t addr,
	// Overlay setting in force.
	input wire logic overlayEn,
	input wire logic [2:0] windowSel,
	// Decode result.
	output logic ramHit,
	output logic overlayHit,
	output logic [8:0] ramIndex
);
	function automatic logic inBlock(input addr_t a, input addr_t base);
		inBlock = (a[`RO_ADDR_W-1:`RO_BLOCK_LSB] == base[`RO_ADDR_W-1:`RO_BLOCK_LSB]);
	endfunction

	addr_t windowBase;
	assign windowBase = `RO_WIN_BASE + (addr_t'(windowSel) << `RO_BLOCK_LSB);
	// The enable gates the window; select bits alone never map anything.
	assign overlayHit = overlayEn && inBlock(addr, windowBase); // see [RQ4]
	// The original RAM range always answers, overlay or not.
	assign ramHit = overlayHit || inBlock(addr, `RO_RAM_BASE); // see [RQ3]
	assign ramIndex = addr[`RO_BLOCK_LSB-1:0];
endmodule
`default_nettype wire

// ---- testbench/flash_port_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module flash_port_model
	import ram_overlay_pkg::*;
#(
	parameter int WAIT = 2
) (
	// Clock.
	input wire logic core_clk,
	// Request from the block.
	input wire addr_t flashAddr,
	input wire logic flashRead,
	input wire logic flashWrite,
	input wire logic [7:0] flashWdata,
	// Answer and traffic count.
	output var logic [7:0] flashRdata,
	output var logic flashAck,
	output var int strobeCount,
	// Last write seen, so that the bench can check what reached flash.
	output var addr_t lastAddr,
	output var logic [7:0] lastWdata
);
	int waitCount;
	initial begin
		waitCount = 0;
		flashRdata = 8'h00;
		flashAck = 1'b0;
		strobeCount = 0;
		lastAddr = 24'h000000;
		lastWdata = 8'h00;
	end
	// Data toggles away from the ack so that a stale byte cannot pass as an answer.
	always @(posedge core_clk) begin
		if (flashAck) begin
			flashAck <= 1'b0;
			flashRdata <= ~flashRdata;
			waitCount <= 0;
		end else if ((flashRead || flashWrite) && waitCount >= WAIT) begin
			flashAck <= 1'b1;
			flashRdata <= flashAddr[7:0] ^ 8'h5a;
			strobeCount <= strobeCount + 1;
			if (flashWrite) begin
				lastAddr <= flashAddr;
				lastWdata <= flashWdata;
			end
		end else begin
			flashRdata <= ~flashRdata;
			waitCount <= (flashRead || flashWrite) ? waitCount + 1 : 0;
		end
	end
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench
	import ram_overlay_pkg::*;
;
	logic core_clk, resetn, hwStandby, swStandby, flashBusy, flashErrorCond;
	logic [2:0] opMode;
	logic [3:0] avs_address, avs_byteenable;
	logic avs_read, avs_write, avs_waitrequest, cpuRead, cpuWrite, cpuAck;
	logic [31:0] avs_writedata, avs_readdata, q;
	addr_t cpuAddr, flashAddr, a, lastAddr;
	logic [7:0] cpuWdata, cpuRdata, flashWdata, flashRdata, d, lastWdata;
	logic flashRead, flashWrite, flashAck, flashErrorFlag, progEraseBlocked;
	int strobeCount, mismatches, check_count;
	ram_overlay_flash_emulation ram_overlay_flash_emulation_i (.core_clk(core_clk),
		.resetn(resetn), .opMode(opMode), .hwStandby(hwStandby), .swStandby(swStandby),
		.flashBusy(flashBusy), .flashErrorCond(flashErrorCond), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .cpuAddr(cpuAddr), .cpuRead(cpuRead),
		.cpuWrite(cpuWrite), .cpuWdata(cpuWdata), .cpuRdata(cpuRdata), .cpuAck(cpuAck),
		.flashAddr(flashAddr), .flashRead(flashRead), .flashWrite(flashWrite),
		.flashWdata(flashWdata), .flashRdata(flashRdata), .flashAck(flashAck),
		.flashErrorFlag(flashErrorFlag), .progEraseBlocked(progEraseBlocked));
	flash_port_model flash_port_model_i (.core_clk(core_clk), .flashAddr(flashAddr),
		.flashRead(flashRead), .flashWrite(flashWrite), .flashWdata(flashWdata),
		.flashRdata(flashRdata), .flashAck(flashAck), .strobeCount(strobeCount),
		.lastAddr(lastAddr), .lastWdata(lastWdata));
	always #10 core_clk = ~core_clk;
	task automatic stop_test();
		if (mismatches == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask
	// The request is held until waitrequest is sampled low at a rising edge.
	task automatic av(input logic wr, input logic [3:0] ad, input logic [31:0] wd);
		@(posedge core_clk);
		avs_address <= ad;
		avs_writedata <= wd;
		avs_read <= !wr;
		avs_write <= wr;
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic cpu(input logic wr, input addr_t ad, input logic [7:0] wd);
		@(posedge core_clk);
		cpuAddr <= ad;
		cpuWdata <= wd;
		cpuRead <= !wr;
		cpuWrite <= wr;
		do @(posedge core_clk); while (cpuAck !== 1'b1);
		d = cpuRdata;
		cpuRead <= 1'b0;
		cpuWrite <= 1'b0;
	endtask
	initial begin
		#100000;
		mismatches++;
		stop_test();
	end
	initial begin
		core_clk = 0; resetn = 0; opMode = 3'h5; hwStandby = 0; swStandby = 0;
		flashBusy = 0; flashErrorCond = 0; avs_address = 0; avs_read = 0; avs_write = 0;
		avs_writedata = 0; avs_byteenable = 4'hf; cpuAddr = 0; cpuRead = 0; cpuWrite = 0;
		cpuWdata = 0; mismatches = 0; check_count = 0;
		repeat (16) @(posedge core_clk);
		resetn <= 1'b1;
		av(0, 4'h0, 0);
		chk("ctrl reset", 32'h70, q);
		av(1, 4'h0, 32'hff);
		av(0, 4'h0, 0);
		chk("ctrl bits", 32'h7f, q);
		// Writes without lane 0 or to another word must leave the control bits alone.
		avs_byteenable <= 4'he;
		av(1, 4'h0, 32'h00);
		avs_byteenable <= 4'hf;
		av(1, 4'h3, 32'h00);
		av(0, 4'h0, 0);
		chk("ignored writes", 32'h7f, q);
		av(0, 4'h3, 0);
		chk("unmapped", 32'h0, q);
		for (int s = 0; s < 8; s++) begin
			a = 24'h01f000 + 24'(s) * 24'h200;
			av(1, 4'h0, 32'h8 | 32'(s));
			cpu(1, a + 24'(s), 8'h10 + 8'(s));
			cpu(0, 24'hfff000 + 24'(s), 8'h00);
			chk("window to ram", 8'h10 + 8'(s), d);
			cpu(1, 24'hfff1ff, 8'he0 + 8'(s));
			cpu(0, a + 24'h1ff, 8'h00);
			chk("ram to window", 8'he0 + 8'(s), d);
		end
		chk("flash strobes", 0, strobeCount);
		av(1, 4'h0, 32'h07);
		cpu(0, 24'h01fe05, 8'h00);
		chk("overlay off", 8'h05 ^ 8'h5a, d);
		chk("flash strobes", 1, strobeCount);
		cpu(1, 24'h01fe10, 8'ha5);
		chk("flash wdata", 8'ha5, lastWdata);
		chk("flash addr", 24'h01fe10, lastAddr);
		chk("flash strobes", 2, strobeCount);
		av(1, 4'h0, 32'h0a);
		swStandby <= 1'b1;
		av(0, 4'h0, 0);
		chk("sw standby", 32'h7a, q);
		swStandby <= 1'b0;
		hwStandby <= 1'b1;
		@(posedge core_clk);
		hwStandby <= 1'b0;
		av(0, 4'h0, 0);
		chk("hw standby", 32'h70, q);
		av(1, 4'h0, 32'h0a);
		opMode <= 3'h2;
		av(0, 4'h0, 0);
		chk("other mode", 32'h70, q);
		av(1, 4'h0, 32'h0c);
		opMode <= 3'h5;
		av(0, 4'h0, 0);
		chk("write ignored", 32'h70, q);
		opMode <= 3'h6;
		av(1, 4'h0, 32'h09);
		av(0, 4'h0, 0);
		chk("mode 6 write", 32'h79, q);
		opMode <= 3'h7;
		av(1, 4'h0, 32'h0b);
		av(0, 4'h0, 0);
		chk("mode 7 write", 32'h7b, q);
		av(1, 4'h0, 32'h00);
		flashErrorCond <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk("error idle", 0, flashErrorFlag);
		flashBusy <= 1'b1;
		repeat (2) @(posedge core_clk);
		flashBusy <= 1'b0;
		flashErrorCond <= 1'b0;
		swStandby <= 1'b1;
		av(0, 4'h0, 0);
		chk("error flag", 32'hf0, q);
		swStandby <= 1'b0;
		chk("blocked", 1, progEraseBlocked);
		hwStandby <= 1'b1;
		@(posedge core_clk);
		hwStandby <= 1'b0;
		av(0, 4'h0, 0);
		chk("hw clears flag", 32'h70, q);
		flashBusy <= 1'b1;
		flashErrorCond <= 1'b1;
		@(posedge core_clk);
		flashBusy <= 1'b0;
		flashErrorCond <= 1'b0;
		av(1, 4'h0, 32'h0f);
		av(0, 4'h0, 0);
		chk("before reset", 32'hff, q);
		resetn <= 1'b0;
		@(posedge core_clk);
		resetn <= 1'b1;
		av(0, 4'h0, 0);
		chk("reset clears", 32'h70, q);
		stop_test();
	end
endmodule
`default_nettype wire
